// file: rtl/spc_port.sv
// Serial port core: host and client byte transfers, registers, pin control
`timescale 1ns/1ps
`default_nettype none
// How it works
// - In host mode a buffer write, and nothing else, starts a byte transfer.
// - With output disabled, bytes are still received and buffered with status updates.
// - Host bit clock is sys clock /4, /16, /64 or half the timer pulse rate.
// - Data shifts most significant bit first, both directions, host and client.
// - With edge select set, first data bit is out before first clock edge.
// - Client shifts only on external clock edges; flag set at final bit.
// - Client runs from external clock; after 8 bits sets the flag for wake.
// - Select pin acts only in mode 4; low select enables transfers and output.
// - Rising select line releases the data output immediately, even mid-byte.
// - High select in mode 4, or port disable, resets port and bit count.
// - Output-as-input setting stops transmission while reception continues.
// - Sleep freezes a host transfer; it resumes where it stopped.
// - Completion wakes the processor only when port interrupt is enabled.
// - Device reset disables the port and aborts any transfer.
// - SPI modes map to polarity and edge bits per standard table.
// - Sample-phase bit picks the host-mode capture point within each bit time.
// - Polarity bit sets clock idle level: 1 high, 0 low.
// - After 8 bits byte goes to buffer, sets full and flag; read clears full.
// - Buffer write during transfer is dropped and sets sticky collision flag.
// - Client byte into an unread buffer sets sticky overflow; byte is lost.
module spc_port
  import spc_pkg::*;
(
  input  wire logic                 sys_clk,      // System clock, 20 MHz
  input  wire logic                 arst_n,       // Async reset, active low
  input  wire logic [ADDR_W-1:0]    awaddr,       // AXI write address
  input  wire logic                 awvalid,      // AXI write address valid
  output logic                      awready,      // AXI write address ready
  input  wire logic [31:0]          wdata,        // AXI write data
  input  wire logic [3:0]           wstrb,        // AXI write strobes
  input  wire logic                 wvalid,       // AXI write data valid
  output logic                      wready,       // AXI write data ready
  output logic [1:0]                bresp,        // AXI write response
  output logic                      bvalid,       // AXI write response valid
  input  wire logic                 bready,       // AXI write response ready
  input  wire logic [ADDR_W-1:0]    araddr,       // AXI read address
  input  wire logic                 arvalid,      // AXI read address valid
  output logic                      arready,      // AXI read address ready
  output logic [31:0]               rdata,        // AXI read data
  output logic [1:0]                rresp,        // AXI read response
  output logic                      rvalid,       // AXI read valid
  input  wire logic                 rready,       // AXI read ready
  input  wire logic                 sckIn,        // Serial clock pin level
  output logic                      sckOut,       // Serial clock drive value
  output logic                      sckOe,        // Serial clock drive enable
  input  wire logic                 sdiIn,        // Serial data in pin
  output logic                      sdoOut,       // Serial data out value
  output logic                      sdoOe,        // Serial data out drive enable
  input  wire logic                 selectIn_n,   // Client select pin, active low
  input  wire logic                 timerTick,    // Periodic timer output pulse
  input  wire logic                 sleepIn,      // Device asleep, host clocks halted
  output logic                      wakeOut,      // Wake request level
  output logic                      irqPrioOut    // Port interrupt priority bit
);
  typedef struct packed {
    spc_state_t  state;
    logic        write_collision;
    logic        ovf;
    logic        en;
    logic        pol;
    logic [3:0]  mode;
    logic        sample_phase;
    logic        cke;
    logic        bufFull;
    logic [7:0]  rxBuf;
    logic [7:0]  txSh;
    logic [7:0]  rxSh;
    logic [3:0]  half;
    logic [5:0]  div;
    logic [3:0]  bitCnt;
    logic        irqFlag;
    logic        irqEn;
    logic        irqPrio;
    logic        outDis;
    logic [2:0]  sync0;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  filt;
    logic        sckLast;
  } spc_core_t;

  spc_core_t q, d;
  spc_reg_if rb ();

  logic       isHost, isClient, selOk, busy, hostTick, byteDone, bufWr;
  logic       sckEdge, leadEdge, trailEdge, sampleEdge, shiftEdge;
  logic [2:0] agree;
  logic [5:0] halfLen;
  logic [7:0] rxNew;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  spc_axil_slave u_slave (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rb      (rb.bus)
  );

  // ------------------------------------------------------------
  // Decode and read mux
  // ------------------------------------------------------------
  always_comb begin
    rb.hit   = 1'b1;
    rb.rdata = 8'h00;
    case (rb.addr)
      OFS_BUF: rb.rdata = q.rxBuf;
      OFS_CTL: rb.rdata = {q.write_collision, q.ovf, q.en, q.pol, q.mode};
      OFS_STS: rb.rdata = {q.sample_phase, q.cke, 5'h00, q.bufFull};
      OFS_IFL: rb.rdata = {4'h0, q.irqFlag, 3'h0};
      OFS_IEN: rb.rdata = {4'h0, q.irqEn, 3'h0};
      OFS_IPR: rb.rdata = {4'h0, q.irqPrio, 3'h0};
      OFS_PIN: rb.rdata = {7'h00, q.outDis};
      default: rb.hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Mode decode and bit-rate timing
  // ------------------------------------------------------------
  assign isHost   = q.en & (q.mode <= MODE_TIMER);
  assign isClient = q.en & ((q.mode == MODE_CL_SS) | (q.mode == MODE_CL_NSS));
  assign selOk    = (q.mode == MODE_CL_NSS) | ~q.filt[PIN_SS];
  assign busy     = (q.state != ST_IDLE);
  assign bufWr    = rb.wrEn & (rb.addr == OFS_BUF);

  always_comb begin
    case (q.mode)
      MODE_DIV16: halfLen = HALF_DIV16;
      MODE_DIV64: halfLen = HALF_DIV64;
      default:    halfLen = HALF_DIV4;
    endcase
  end
  // Timer mode toggles the clock once per timer pulse: bit rate is half the pulse rate
  assign hostTick = (q.mode == MODE_TIMER) ? timerTick : (q.div == halfLen - 6'h01);

  // Client clock edges seen through the filtered pin levels
  assign sckEdge    = q.filt[PIN_SCK] ^ q.sckLast;
  assign leadEdge   = sckEdge & (q.filt[PIN_SCK] != q.pol);
  assign trailEdge  = sckEdge & (q.filt[PIN_SCK] == q.pol);
  assign sampleEdge = q.cke ? leadEdge : trailEdge;
  assign shiftEdge  = q.cke ? trailEdge : (leadEdge & (q.bitCnt != 4'h0));

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d        = q;
    byteDone = 1'b0;
    // Host data is launched off our own clock edges, so it is read directly; the filter lag would eat a Fosc/4 bit
    rxNew    = {q.rxSh[6:0], (isHost ? sdiIn : q.filt[PIN_SDI])};
    agree    = ~(q.sync1 ^ q.sync2);
    d.sync0  = {sckIn, sdiIn, selectIn_n};
    d.sync1  = q.sync0;
    d.sync2  = q.sync1;
    // A pin change counts only once the last two stages agree
    d.filt    = (agree & q.sync2) | (~agree & q.filt);
    d.sckLast = q.filt[PIN_SCK];

    // Software writes first, so a same-cycle hardware set wins below
    if (rb.wrEn) begin
      case (rb.addr)
        OFS_CTL: begin
          d.write_collision = q.write_collision & rb.wdata[CTL_WRITE_COLLISION];
          d.ovf  = q.ovf & rb.wdata[CTL_OVF];
          d.en   = rb.wdata[CTL_EN];
          if (!q.en) begin
            d.pol  = rb.wdata[CTL_POL];
            d.mode = rb.wdata[3:0];
          end
        end
        OFS_STS: begin
          if (!q.en) begin
            d.sample_phase = rb.wdata[STS_SMP];
            d.cke = rb.wdata[STS_CKE];
          end
        end
        OFS_IFL: d.irqFlag = rb.wdata[IRQ_BIT];
        OFS_IEN: d.irqEn   = rb.wdata[IRQ_BIT];
        OFS_IPR: d.irqPrio = rb.wdata[IRQ_BIT];
        OFS_PIN: d.outDis  = rb.wdata[PIN_ODIS];
        default: d.outDis  = q.outDis;
      endcase
    end
    if (rb.rdEn && rb.addr == OFS_BUF) begin
      d.bufFull = 1'b0;
    end

    if (bufWr) begin
      if (busy) begin
        d.write_collision = 1'b1;
      end else begin
        d.txSh = rb.wdata;
        if (isHost) begin
          d.state = ST_HOST;
          d.half  = 4'h0;
          d.div   = 6'h00;
        end
      end
    end

    case (q.state)
      ST_HOST: begin
        // Asleep: counters and shifters simply hold
        if (!sleepIn) begin
          d.div = hostTick ? 6'h00 : q.div + 6'h01;
          if (hostTick) begin
            d.half = q.half + 4'h1;
            if (q.half[0] == q.sample_phase) begin
              d.rxSh = rxNew;
            end else begin
              rxNew = q.rxSh;
            end
            if (q.half[0]) begin
              d.txSh = {q.txSh[6:0], 1'b0};
            end
            if (q.half == HALF_LAST) begin
              byteDone = 1'b1;
              d.state  = ST_IDLE;
            end
          end
        end
      end
      ST_IDLE, ST_CLIENT: begin
        if (isClient && selOk) begin
          if (shiftEdge) begin
            d.txSh = {q.txSh[6:0], 1'b0};
          end
          if (sampleEdge) begin
            d.rxSh   = rxNew;
            d.bitCnt = q.bitCnt + 4'h1;
            d.state  = ST_CLIENT;
            if (q.bitCnt == BITS_LAST) begin
              byteDone = 1'b1;
              d.bitCnt = 4'h0;
              d.state  = ST_IDLE;
            end
          end
        end
      end
      default: d.state = ST_IDLE;
    endcase

    if (byteDone) begin
      d.irqFlag = 1'b1;
      if (isClient && q.bufFull && !(rb.rdEn && rb.addr == OFS_BUF)) begin
        d.ovf = 1'b1;
      end else begin
        d.rxBuf   = rxNew;
        d.bufFull = 1'b1;
      end
    end

    // Disable or deselect drops the byte in flight and clears the count
    if (!q.en || (isClient && !selOk)) begin
      d.state  = ST_IDLE;
      d.bitCnt = 4'h0;
      d.half   = 4'h0;
      d.div    = 6'h00;
    end
  end

  // Reset clears the enable, so the port comes up off with nothing in flight
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q       <= '0;
      q.state <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Pins and side outputs
  // ------------------------------------------------------------
  assign sckOut = (q.state == ST_HOST) ? (q.pol ^ (q.cke ? q.half[0] : ~q.half[0])) : q.pol;
  assign sckOe  = isHost;
  assign sdoOut = q.txSh[7];
  // Raw select pin so the release is not delayed by the synchroniser
  assign sdoOe  = ~q.outDis & (isHost | (isClient & ((q.mode == MODE_CL_NSS) | ~selectIn_n)));
  assign wakeOut    = q.irqFlag & q.irqEn;
  assign irqPrioOut = q.irqPrio;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [3:0] pulseCnt;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseCnt <= 4'h0;
    end else if (bufWr && !busy) begin
      pulseCnt <= 4'h0;
    end else if (q.state == ST_HOST && sckOut != q.pol && $past(sckOut) == q.pol) begin
      pulseCnt <= pulseCnt + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  host_start_a: assert property (bufWr && !busy && isHost |=> q.state == ST_HOST)
    else $error("host transfer did not start on buffer write");
  msb_first_a: assert property (bufWr && !busy && isHost |=> sdoOut == $past(rb.wdata[7]))
    else $error("first data bit is not the msb");
  eight_pulses_a: assert property (byteDone && q.state == ST_HOST |-> pulseCnt == 4'h8)
    else $error("host transfer did not give eight pulses");
  collision_a: assert property (bufWr && busy && !hostTick && !shiftEdge |=> q.write_collision && $stable(q.txSh))
    else $error("collision not flagged");
  full_on_done_a: assert property (byteDone && !(isClient && q.bufFull) |=> q.bufFull && q.irqFlag)
    else $error("completed byte did not fill buffer");
  overflow_a: assert property (byteDone && isClient && q.bufFull && !rb.rdEn |=> q.ovf && $stable(q.rxBuf))
    else $error("overflow not flagged or buffer overwritten");
  release_out_a: assert property (isClient && q.mode == MODE_CL_SS && selectIn_n |-> !sdoOe)
    else $error("data output driven while deselected");
  deselect_reset_a: assert property (isClient && q.mode == MODE_CL_SS && q.filt[PIN_SS] |=> q.bitCnt == 4'h0)
    else $error("bit count not cleared on deselect");
  sleep_hold_a: assert property (q.state == ST_HOST && sleepIn && q.en |=> $stable(q.half) && $stable(q.txSh))
    else $error("host transfer moved during sleep");
  wake_gate_a: assert property (byteDone && !q.irqEn ##1 !rb.wrEn [*2] |-> !wakeOut)
    else $error("wake raised with interrupt disabled");
  idle_level_a: assert property (q.state == ST_IDLE |-> sckOut == q.pol)
    else $error("clock not at idle level");

  host_done_c: cover property (byteDone && q.state == ST_HOST);
  client_done_c: cover property (byteDone && isClient);
  collision_c: cover property (bufWr && busy);
  overflow_c: cover property (byteDone && isClient && q.bufFull);
endmodule // spc_port
`default_nettype wire

// file: rtl/spc_pkg.sv
// Shared constants and types of the serial host/client port
package spc_pkg;
  localparam int unsigned ADDR_W = 8;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_BUF  = 8'h00;
  localparam logic [7:0] OFS_CTL  = 8'h04;
  localparam logic [7:0] OFS_STS  = 8'h08;
  localparam logic [7:0] OFS_IFL  = 8'h0C;
  localparam logic [7:0] OFS_IEN  = 8'h10;
  localparam logic [7:0] OFS_IPR  = 8'h14;
  localparam logic [7:0] OFS_PIN  = 8'h18;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned CTL_WRITE_COLLISION = 7;
  localparam int unsigned CTL_OVF  = 6;
  localparam int unsigned CTL_EN   = 5;
  localparam int unsigned CTL_POL  = 4;
  localparam int unsigned STS_SMP  = 7;
  localparam int unsigned STS_CKE  = 6;
  localparam int unsigned STS_BF   = 0;
  localparam int unsigned IRQ_BIT  = 3;
  localparam int unsigned PIN_ODIS = 0;
  localparam int unsigned PIN_SCK  = 2;
  localparam int unsigned PIN_SDI  = 1;
  localparam int unsigned PIN_SS   = 0;
  // ------------------------------------------------------------
  // Mode codes, reset values, rate counts
  // ------------------------------------------------------------
  localparam logic [3:0] MODE_DIV4   = 4'h0;
  localparam logic [3:0] MODE_DIV16  = 4'h1;
  localparam logic [3:0] MODE_DIV64  = 4'h2;
  localparam logic [3:0] MODE_TIMER  = 4'h3;
  localparam logic [3:0] MODE_CL_SS  = 4'h4;
  localparam logic [3:0] MODE_CL_NSS = 4'h5;
  localparam logic [7:0] RST_REG     = 8'h00;
  localparam logic [5:0] HALF_DIV4   = 6'h02;
  localparam logic [5:0] HALF_DIV16  = 6'h08;
  localparam logic [5:0] HALF_DIV64  = 6'h20;
  localparam logic [3:0] BITS_LAST   = 4'h7;
  localparam logic [3:0] HALF_LAST   = 4'hF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_HOST   = 3'b010,
    ST_CLIENT = 3'b100
  } spc_state_t;
endpackage

// file: rtl/spc_reg_if.sv
// Simple register access carrier between bus slave and port core
`timescale 1ns/1ps
`default_nettype none
interface spc_reg_if;
  logic        wrEn;
  logic        rdEn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        hit;
  modport bus  (output wrEn, output rdEn, output addr, output wdata, input rdata, input hit);
  modport core (input wrEn, input rdEn, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// file: rtl/spc_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into single-cycle register accesses
`timescale 1ns/1ps
`default_nettype none
module spc_axil_slave
  import spc_pkg::*;
(
  input  wire logic                 sys_clk,   // System clock
  input  wire logic                 arst_n,    // Async reset
  input  wire logic [ADDR_W-1:0]    awaddr,    // Write address
  input  wire logic                 awvalid,   // Write address valid
  output logic                      awready,   // Write address ready
  input  wire logic [31:0]          wdata,     // Write data
  input  wire logic [3:0]           wstrb,     // Write strobes
  input  wire logic                 wvalid,    // Write data valid
  output logic                      wready,    // Write data ready
  output logic [1:0]                bresp,     // Write response
  output logic                      bvalid,    // Write response valid
  input  wire logic                 bready,    // Write response ready
  input  wire logic [ADDR_W-1:0]    araddr,    // Read address
  input  wire logic                 arvalid,   // Read address valid
  output logic                      arready,   // Read address ready
  output logic [31:0]               rdata,     // Read data
  output logic [1:0]                rresp,     // Read response
  output logic                      rvalid,    // Read valid
  input  wire logic                 rready,    // Read ready
  spc_reg_if.bus                    rb         // Register access
);
  typedef struct packed {
    logic              awHave;
    logic [ADDR_W-1:0] awAddr;
    logic              wHave;
    logic [7:0]        wByte;
    logic              wLane;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arHave;
    logic [ADDR_W-1:0] arAddr;
    logic              rValid;
    logic [7:0]        rByte;
    logic [1:0]        rResp;
  } spc_axi_t;

  spc_axi_t q, d;
  logic doWr, doRd;

  assign awready = ~q.awHave;
  assign wready  = ~q.wHave;
  assign arready = ~q.arHave & ~q.rValid;
  assign bvalid  = q.bValid;
  assign bresp   = q.bResp;
  assign rvalid  = q.rValid;
  assign rresp   = q.rResp;
  assign rdata   = {24'h000000, q.rByte};

  // Write wins a shared cycle; the read simply waits one more cycle
  assign doWr     = q.awHave & q.wHave & ~q.bValid;
  assign doRd     = q.arHave & ~doWr;
  assign rb.addr  = doWr ? q.awAddr : q.arAddr;
  assign rb.wdata = q.wByte;
  assign rb.wrEn  = doWr & q.wLane & rb.hit;
  assign rb.rdEn  = doRd & rb.hit;

  always_comb begin
    d = q;
    if (awvalid && !q.awHave) begin
      d.awHave = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && !q.wHave) begin
      d.wHave = 1'b1;
      d.wByte = wdata[7:0];
      d.wLane = wstrb[0];
    end
    if (q.bValid && bready) begin
      d.bValid = 1'b0;
    end
    if (doWr) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = rb.hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (arvalid && !q.arHave && !q.rValid) begin
      d.arHave = 1'b1;
      d.arAddr = araddr;
    end
    if (q.rValid && rready) begin
      d.rValid = 1'b0;
    end
    if (doRd) begin
      d.arHave = 1'b0;
      d.rValid = 1'b1;
      d.rByte  = rb.hit ? rb.rdata : 8'h00;
      d.rResp  = rb.hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // spc_axil_slave
`default_nettype wire

// file: dv/spc_peer.sv
// Behavioural SPI client facing the port in host mode
`timescale 1ns/1ps
`default_nettype none
module spc_peer (
  input  wire logic       sck,    // Serial clock from the port
  input  wire logic       sdo,    // Data from the port
  input  wire logic [7:0] txByte, // Byte to send next frame
  input  wire logic       load,   // Reload the send byte
  output logic            sdi,    // Data towards the port
  output logic [7:0]      rxByte  // Last byte captured
);
  logic [7:0] txQ;
  // Capture on the rising edge, most significant bit first
  always @(posedge sck) rxByte <= {rxByte[6:0], sdo};
  // Inverted fill keeps the line moving once the byte is spent
  always @(negedge sck or posedge load) begin
    if (load) txQ <= txByte;
    else txQ <= {txQ[6:0], ~txQ[0]};
  end
  assign sdi = txQ[7];
endmodule // spc_peer
`default_nettype wire

// file: dv/spi_host_client_port_test.sv
// Self-checking bench of the serial host/client port
`timescale 1ns/1ps
`default_nettype none
module spi_host_client_port_test;
  import spc_pkg::*;
  logic        sys_clk = 1'h0;
  logic        arst_n = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, peerTx = 8'h00, peerRx;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, load = 1'h0;
  logic        cliSck = 1'h0, cliSdi = 1'h0, selN = 1'h1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        sckOut, sckOe, sdoOut, sdoOe, wakeOut, sdi;
  int          fails = 0, samplesChecked = 0;
  always #25 sys_clk = ~sys_clk;
  spc_port spc_port_inst (.sys_clk(sys_clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sckIn(sckOe ? sckOut : cliSck),
    .sckOut(sckOut), .sckOe(sckOe), .sdiIn(sckOe ? sdi : cliSdi), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .selectIn_n(selN), .timerTick(1'h0),
    .sleepIn(1'h0), .wakeOut(wakeOut), .irqPrioOut());
  spc_peer spc_peer_inst (.sck(sckOut), .sdo(sdoOut), .txByte(peerTx), .load(load), .sdi(sdi),
    .rxByte(peerRx));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    int n;
    @(posedge sys_clk);
    aw = 1'h1;
    w = 1'h1;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while ((aw || w) && ++n < 99) begin
      @(posedge sys_clk);
      if (awready === 1'h1) aw = 1'h0;
      if (wready === 1'h1) w = 1'h0;
      awvalid <= aw;
      wvalid <= w;
    end
    do @(posedge sys_clk); while (bvalid !== 1'h1 && ++n < 99);
    bready <= 1'h0;
    if (n >= 99) fails++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge sys_clk); while (arready !== 1'h1 && ++n < 99);
    arvalid <= 1'h0;
    do @(posedge sys_clk); while (rvalid !== 1'h1 && ++n < 99);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n >= 99) fails++;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFS_CTL, d, r);
    chk(d, 32'h0);
    rd(OFS_STS, d, r);
    chk(d, 32'h0);
    chk(sckOe, 1'h0);
    rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
  endtask
  task automatic t_host(input logic [3:0] m, input logic [7:0] tx, input logic [7:0] rx);
    logic [31:0] d;
    logic [1:0]  r;
    int          hi;
    int          half;
    hi = 0;
    half = (m == MODE_DIV4) ? HALF_DIV4 : (m == MODE_DIV16) ? HALF_DIV16 : HALF_DIV64;
    wr(OFS_CTL, 32'h0);
    wr(OFS_STS, 32'h1 << STS_CKE);
    wr(OFS_CTL, (32'h1 << CTL_EN) | m);
    peerTx <= rx;
    load <= 1'h1;
    @(posedge sys_clk);
    load <= 1'h0;
    wr(OFS_BUF, tx);
    repeat (16 * half + 8) begin
      @(posedge sys_clk);
      if (sckOut === 1'h1) hi++;
    end
    chk(hi, 8 * half);
    chk(sckOut, 1'h0);
    rd(OFS_STS, d, r);
    chk(d[STS_BF], 1'h1);
    rd(OFS_BUF, d, r);
    chk(d, rx);
    chk(peerRx, tx);
    rd(OFS_STS, d, r);
    chk(d[STS_BF], 1'h0);
  endtask
  // Port is left enabled at the slowest rate by the previous scenario
  task automatic t_collide();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFS_IFL, 32'h0);
    wr(OFS_IEN, 32'h1 << IRQ_BIT);
    chk(wakeOut, 1'h0);
    wr(OFS_BUF, 32'h11);
    wr(OFS_BUF, 32'h22);
    rd(OFS_CTL, d, r);
    chk(d[CTL_WRITE_COLLISION], 1'h1);
    repeat (16 * HALF_DIV64 + 8) @(posedge sys_clk);
    chk(wakeOut, 1'h1);
    chk(peerRx, 8'h11);
    wr(OFS_CTL, (32'h1 << CTL_EN) | MODE_DIV64);
    rd(OFS_CTL, d, r);
    chk(d[CTL_WRITE_COLLISION], 1'h0);
  endtask
  // Bench plays the external host: clock idles low before enable, select low for the byte
  task automatic t_client(input logic [7:0] tx, input logic [7:0] rx);
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  got;
    rd(OFS_BUF, d, r);
    wr(OFS_IFL, 32'h0);
    wr(OFS_CTL, 32'h0);
    wr(OFS_STS, 32'h1 << STS_CKE);
    cliSck <= 1'h0;
    selN <= 1'h0;
    wr(OFS_CTL, (32'h1 << CTL_EN) | MODE_CL_SS);
    wr(OFS_BUF, tx);
    for (int i = 7; i >= 0; i--) begin
      cliSdi <= rx[i];
      repeat (8) @(posedge sys_clk);
      got[i] = sdoOut;
      cliSck <= 1'h1;
      repeat (8) @(posedge sys_clk);
      cliSck <= 1'h0;
    end
    repeat (8) @(posedge sys_clk);
    chk(got, tx);
    chk(sdoOe, 1'h1);
    selN <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk(sdoOe, 1'h0);
    rd(OFS_BUF, d, r);
    chk(d, rx);
    rd(OFS_IFL, d, r);
    chk(d[IRQ_BIT], 1'h1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'h1;
    t_reset();
    t_host(MODE_DIV4, 8'hA5, 8'h3C);
    t_host(MODE_DIV16, 8'h81, 8'h7E);
    t_host(MODE_DIV64, 8'h5A, 8'hC3);
    t_collide();
    t_client(8'h96, 8'h4B);
    wrap_up();
  end
  // Whole run needs under two thousand cycles
  initial begin
    repeat (9000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
endmodule // spi_host_client_port_test
`default_nettype wire
